// ===== src/decode_pkg.sv
// Opcode map, instruction classes and reset values for the decode core.
package decode_pkg;

  // Opcode high nibble selects the group.
  localparam logic [3:0] GRP_ADD = 4'h0;
  localparam logic [3:0] GRP_ADDC = 4'h1;
  localparam logic [3:0] GRP_SUB = 4'h2;
  localparam logic [3:0] GRP_SUBC = 4'h3;
  localparam logic [3:0] GRP_AND = 4'h4;
  localparam logic [3:0] GRP_OR = 4'h5;
  localparam logic [3:0] GRP_XOR = 4'h6;
  localparam logic [3:0] GRP_CMP = 4'h7;
  localparam logic [3:0] GRP_MOV = 4'h8;
  localparam logic [3:0] GRP_MISC = 4'h9;
  localparam logic [3:0] GRP_BIT = 4'ha;
  localparam logic [3:0] GRP_STEP = 4'hb;
  localparam logic [3:0] GRP_FLOW = 4'hc;
  localparam logic [3:0] GRP_SYS = 4'hd;
  localparam logic [3:0] GRP_MAC = 4'he;

  // Register-only group, low nibble.
  localparam logic [3:0] M_PROD_S = 4'h0;
  localparam logic [3:0] M_PROD_U = 4'h1;
  localparam logic [3:0] M_QUOT_S = 4'h2;
  localparam logic [3:0] M_QUOT_U = 4'h3;
  localparam logic [3:0] M_QUOTL_S = 4'h4;
  localparam logic [3:0] M_QUOTL_U = 4'h5;
  localparam logic [3:0] M_ONES = 4'h6;
  localparam logic [3:0] M_ONES_B = 4'h7;
  localparam logic [3:0] M_TWOS = 4'h8;
  localparam logic [3:0] M_TWOS_B = 4'h9;
  localparam logic [3:0] M_SHIFT_L = 4'ha;
  localparam logic [3:0] M_SHIFT_R = 4'hb;
  localparam logic [3:0] M_ROT_L = 4'hc;
  localparam logic [3:0] M_ROT_R = 4'hd;
  localparam logic [3:0] M_SIGN_SHR = 4'he;
  localparam logic [3:0] M_NORM = 4'hf;

  // Bit group, low nibble.
  localparam logic [3:0] B_CLEAR = 4'h0;
  localparam logic [3:0] B_SET = 4'h1;
  localparam logic [3:0] B_COPY = 4'h2;
  localparam logic [3:0] B_COPY_N = 4'h3;
  localparam logic [3:0] B_AND = 4'h4;
  localparam logic [3:0] B_OR = 4'h5;
  localparam logic [3:0] B_XOR = 4'h6;
  localparam logic [3:0] B_CMP = 4'h7;
  localparam logic [3:0] B_FIELD_L = 4'h8;
  localparam logic [3:0] B_FIELD_H = 4'h9;
  localparam logic [3:0] B_JHI = 4'ha;
  localparam logic [3:0] B_JHI_CLR = 4'hb;
  localparam logic [3:0] B_JLO = 4'hc;
  localparam logic [3:0] B_JLO_SET = 4'hd;

  // Flow group, low nibble.
  localparam logic [3:0] F_JUMP = 4'h0;
  localparam logic [3:0] F_CALL = 4'h1;
  localparam logic [3:0] F_PUSH_CALL = 4'h2;
  localparam logic [3:0] F_TRAP = 4'h3;
  localparam logic [3:0] F_PUSH = 4'h4;
  localparam logic [3:0] F_POP = 4'h5;
  localparam logic [3:0] F_SWAP = 4'h6;
  localparam logic [3:0] F_RET = 4'h7;
  localparam logic [3:0] F_RET_POP = 4'h8;
  localparam logic [3:0] F_RETI = 4'h9;

  // System group, low nibble.
  localparam logic [3:0] Y_NOP = 4'h0;
  localparam logic [3:0] Y_SLEEP = 4'h1;
  localparam logic [3:0] Y_PAGE = 4'h2;
  localparam logic [3:0] Y_PAGE_I = 4'h3;
  localparam logic [3:0] Y_PAGE_R = 4'h4;
  localparam logic [3:0] Y_PAGE_RI = 4'h5;

  // Accumulator group, low nibble.
  localparam logic [3:0] C_MUL = 4'h0;
  localparam logic [3:0] C_MAC = 4'h1;
  localparam logic [3:0] C_ADD = 4'h2;
  localparam logic [3:0] C_SUB = 4'h3;
  localparam logic [3:0] C_LOAD = 4'h4;
  localparam logic [3:0] C_STORE = 4'h5;
  localparam logic [3:0] C_CMP = 4'h6;
  localparam logic [3:0] C_MAX = 4'h7;
  localparam logic [3:0] C_MIN = 4'h8;
  localparam logic [3:0] C_ABS = 4'h9;
  localparam logic [3:0] C_RND = 4'ha;
  localparam logic [3:0] C_MOV = 4'hb;
  localparam logic [3:0] C_NEG = 4'hc;
  localparam logic [3:0] C_NOP = 4'hd;

  localparam logic [2:0] LEN_SHORT = 3'h2;
  localparam logic [2:0] LEN_LONG = 3'h4;

  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_V = 2;
  localparam int FLAG_N = 3;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [31:0] ROUND_BIAS = 32'h0000_8000;
  localparam logic [31:0] ROUND_MASK = 32'hffff_0000;
  localparam int TRAP_SHIFT = 2;

  typedef enum logic [2:0] {
    c_alu, c_misc, c_bit, c_step, c_flow, c_sys, c_mac, c_bad
  } op_class_e;

endpackage

// ===== src/insn_decode_exec.sv
// Single-cycle instruction decode and execute core.
`timescale 1ns/10ps
module insn_decode_exec #(
  parameter int STACK_DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [31:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [3:0] dbg_sel_i,
  output logic instr_ready_o,
  output logic [2:0] len_o,
  output logic [15:0] pc_o,
  output logic [15:0] pc_next_o,
  output logic retire_o,
  output logic illegal_o,
  output logic [3:0] flags_o,
  output logic [31:0] md_o,
  output logic [31:0] acc_o,
  output logic [9:0] page_o,
  output logic page_active_o,
  output logic reg_ext_o,
  output logic [15:0] dbg_data_o
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  logic [15:0] regs_r [16];
  logic [15:0] stack_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [15:0] pc_r;
  logic [3:0] flags_r;
  logic [31:0] md_r;
  logic [31:0] acc_r;
  logic [2:0] seq_r;
  logic [9:0] page_r;
  logic reg_ext_r;

  logic [7:0] op;
  logic [3:0] grp, lo, rd, rs;
  logic [15:0] imm, a, srcv, pc_seq;
  logic [2:0] len;
  decode_pkg::op_class_e cls;

  assign op = instr_i[7:0];
  assign grp = op[7:4];
  assign lo = op[3:0];
  assign rd = instr_i[15:12];
  assign rs = instr_i[11:8];
  assign imm = instr_i[31:16];
  assign a = regs_r[rd];
  assign srcv = regs_r[rs];

  length_decode u_len (
    .opcode_i(op),
    .len_o(len),
    .cls_o(cls)
  );

  // The fetch pointer moves on before the instruction executes.
  assign len_o = len;
  assign pc_seq = pc_r + {13'h0000, len};
  assign pc_next_o = pc_seq;
  assign instr_ready_o = 1'b1;
  assign page_active_o = seq_r != 3'h0;
  assign reg_ext_o = reg_ext_r && (seq_r != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Datapath helpers

  // Byte operands move to the top lane so carry and sign come from bit 15.
  logic [15:0] opnd, aa, bb, cin_v;
  logic [16:0] sum;
  logic is_sub, alu_v;
  always_comb begin
    opnd = op[0] ? imm : srcv;
    aa = op[1] ? {a[7:0], 8'h00} : a;
    bb = op[1] ? {opnd[7:0], 8'h00} : opnd;
    cin_v = op[1] ? {7'h00, flags_r[decode_pkg::FLAG_C], 8'h00}
                  : {15'h0000, flags_r[decode_pkg::FLAG_C]};
    case (grp)
      decode_pkg::GRP_ADD: sum = {1'b0, aa} + {1'b0, bb};
      decode_pkg::GRP_ADDC: sum = {1'b0, aa} + {1'b0, bb} + {1'b0, cin_v};
      decode_pkg::GRP_SUB: sum = {1'b0, aa} - {1'b0, bb};
      decode_pkg::GRP_CMP: sum = {1'b0, aa} - {1'b0, bb};
      decode_pkg::GRP_SUBC: sum = {1'b0, aa} - {1'b0, bb} - {1'b0, cin_v};
      decode_pkg::GRP_AND: sum = {1'b0, aa & bb};
      decode_pkg::GRP_OR: sum = {1'b0, aa | bb};
      decode_pkg::GRP_XOR: sum = {1'b0, aa ^ bb};
      default: sum = {1'b0, bb};
    endcase
    is_sub = (grp == decode_pkg::GRP_SUB) || (grp == decode_pkg::GRP_SUBC) ||
             (grp == decode_pkg::GRP_CMP);
    if (is_sub) begin
      alu_v = (aa[15] != bb[15]) && (sum[15] != aa[15]);
    end else begin
      alu_v = (aa[15] == bb[15]) && (sum[15] != aa[15]);
    end
  end

  logic [31:0] prod_s, prod_u, qls, rls, qlu, rlu, dvx;
  logic [15:0] dv, qs, rsm, qu, ru;
  assign prod_s = {{16{a[15]}}, a} * {{16{srcv[15]}}, srcv};
  assign prod_u = {16'h0000, a} * {16'h0000, srcv};
  // A zero divisor is replaced so the quotient is never unknown.
  assign dv = (srcv == 16'h0000) ? 16'h0001 : srcv;
  assign dvx = {{16{dv[15]}}, dv};
  assign qs = $signed(md_r[15:0]) / $signed(dv);
  assign rsm = $signed(md_r[15:0]) % $signed(dv);
  assign qu = md_r[15:0] / dv;
  assign ru = md_r[15:0] % dv;
  assign qls = $signed(md_r) / $signed(dvx);
  assign rls = $signed(md_r) % $signed(dvx);
  assign qlu = md_r / {16'h0000, dv};
  assign rlu = md_r % {16'h0000, dv};

  function automatic logic [15:0] norm_count(input logic [15:0] v);
    logic [15:0] n;
    n = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        n = 16'(15 - i);
      end
    end
    return n;
  endfunction

  function automatic logic [15:0] put_bit(input logic [15:0] v,
                                          input logic [3:0] n,
                                          input logic b);
    logic [15:0] m;
    m = 16'h0001 << n;
    return b ? (v | m) : (v & ~m);
  endfunction

  logic b1, b2;
  logic [15:0] b2w, xsel, jrel;
  logic [31:0] mx;
  logic [32:0] acc_dif;
  assign b1 = a[rs];
  assign b2w = regs_r[instr_i[31:28]];
  assign b2 = b2w[instr_i[27:24]];
  assign jrel = pc_seq + {{7{imm[7]}}, imm[7:0], 1'b0};
  assign mx = {a, srcv};
  assign acc_dif = {1'b0, acc_r} - {1'b0, mx};
  assign xsel = lo[2] ? imm : srcv;

  ////////////////////////////////////////////////////////////////////////////
  // Execute

  logic wr_en;
  logic [3:0] wr_idx;
  logic [15:0] wr_val, pc_nxt, push0, push1, step;
  logic [3:0] fl_nxt;
  logic [31:0] md_nxt, acc_nxt;
  logic [1:0] push_n, pop_n;
  logic [16:0] cmp_d;

  always_comb begin
    wr_en = 1'b0;
    wr_idx = rd;
    wr_val = 16'h0000;
    fl_nxt = flags_r;
    md_nxt = md_r;
    acc_nxt = acc_r;
    pc_nxt = pc_seq;
    push_n = 2'h0;
    pop_n = 2'h0;
    push0 = a;
    push1 = pc_seq;
    cmp_d = {1'b0, a} - {1'b0, xsel};
    step = lo[0] ? 16'h0002 : 16'h0001;
    case (cls)
      decode_pkg::c_alu: begin
        wr_en = grp != decode_pkg::GRP_CMP;
        wr_val = op[1] ? {a[15:8], sum[15:8]} : sum[15:0];
        fl_nxt[decode_pkg::FLAG_Z] = sum[15:0] == 16'h0000;
        fl_nxt[decode_pkg::FLAG_N] = sum[15];
        fl_nxt[decode_pkg::FLAG_C] = (grp <= decode_pkg::GRP_SUBC) &&
                                     sum[16];
        fl_nxt[decode_pkg::FLAG_V] = (grp <= decode_pkg::GRP_SUBC ||
                                      grp == decode_pkg::GRP_CMP) && alu_v;
        if (grp == decode_pkg::GRP_CMP) begin
          fl_nxt[decode_pkg::FLAG_C] = sum[16];
        end
      end
      decode_pkg::c_misc: begin
        wr_en = 1'b1;
        case (lo)
          decode_pkg::M_PROD_S: begin
            wr_en = 1'b0;
            md_nxt = prod_s;
          end
          decode_pkg::M_PROD_U: begin
            wr_en = 1'b0;
            md_nxt = prod_u;
          end
          decode_pkg::M_QUOT_S, decode_pkg::M_QUOT_U,
          decode_pkg::M_QUOTL_S, decode_pkg::M_QUOTL_U: begin
            wr_en = 1'b0;
            fl_nxt[decode_pkg::FLAG_V] = srcv == 16'h0000;
            if (srcv != 16'h0000) begin
              case (lo)
                decode_pkg::M_QUOT_S: md_nxt = {rsm, qs};
                decode_pkg::M_QUOT_U: md_nxt = {ru, qu};
                decode_pkg::M_QUOTL_S: md_nxt = {rls[15:0], qls[15:0]};
                default: md_nxt = {rlu[15:0], qlu[15:0]};
              endcase
            end
          end
          decode_pkg::M_ONES: wr_val = ~a;
          decode_pkg::M_ONES_B: wr_val = {a[15:8], ~a[7:0]};
          decode_pkg::M_TWOS: wr_val = 16'h0000 - a;
          decode_pkg::M_TWOS_B: wr_val = {a[15:8], 8'h00 - a[7:0]};
          decode_pkg::M_SHIFT_L: wr_val = a << rs;
          decode_pkg::M_SHIFT_R: wr_val = a >> rs;
          decode_pkg::M_ROT_L: wr_val = (a << rs) | (a >> (5'h10 - {1'b0, rs}));
          decode_pkg::M_ROT_R: wr_val = (a >> rs) | (a << (5'h10 - {1'b0, rs}));
          decode_pkg::M_SIGN_SHR: wr_val = $signed(a) >>> rs;
          default: begin
            wr_idx = instr_i[31:28];
            wr_val = norm_count(srcv);
          end
        endcase
        if (wr_en) begin
          fl_nxt[decode_pkg::FLAG_Z] = wr_val == 16'h0000;
          fl_nxt[decode_pkg::FLAG_N] = wr_val[15];
        end
      end
      decode_pkg::c_bit: begin
        wr_en = 1'b1;
        case (lo)
          decode_pkg::B_CLEAR: wr_val = put_bit(a, rs, 1'b0);
          decode_pkg::B_SET: wr_val = put_bit(a, rs, 1'b1);
          decode_pkg::B_COPY: wr_val = put_bit(a, rs, b2);
          decode_pkg::B_COPY_N: wr_val = put_bit(a, rs, !b2);
          decode_pkg::B_AND: wr_val = put_bit(a, rs, b1 & b2);
          decode_pkg::B_OR: wr_val = put_bit(a, rs, b1 | b2);
          decode_pkg::B_XOR: wr_val = put_bit(a, rs, b1 ^ b2);
          decode_pkg::B_CMP: begin
            wr_en = 1'b0;
            fl_nxt = {b1, 1'b0, b1 == b2, b2};
          end
          decode_pkg::B_FIELD_L:
            wr_val = {a[15:8], (a[7:0] & ~imm[7:0]) | (imm[15:8] & imm[7:0])};
          decode_pkg::B_FIELD_H:
            wr_val = {(a[15:8] & ~imm[7:0]) | (imm[15:8] & imm[7:0]), a[7:0]};
          decode_pkg::B_JHI, decode_pkg::B_JHI_CLR: begin
            wr_en = b1 && lo[0];
            wr_val = put_bit(a, rs, 1'b0);
            if (b1) begin
              pc_nxt = jrel;
            end
          end
          default: begin
            wr_en = !b1 && lo[0];
            wr_val = put_bit(a, rs, 1'b1);
            if (!b1) begin
              pc_nxt = jrel;
            end
          end
        endcase
      end
      decode_pkg::c_step: begin
        wr_en = 1'b1;
        if (!lo[3]) begin
          fl_nxt = {cmp_d[15], (a[15] != xsel[15]) && (cmp_d[15] != a[15]),
                    cmp_d[15:0] == 16'h0000, cmp_d[16]};
          wr_val = lo[1] ? a + step : a - step;
        end else begin
          wr_val = lo[0] ? {8'h00, xsel[7:0]}
                         : {{8{xsel[7]}}, xsel[7:0]};
        end
      end
      decode_pkg::c_flow: begin
        case (lo)
          decode_pkg::F_JUMP: pc_nxt = imm;
          decode_pkg::F_CALL: begin
            push_n = 2'h1;
            push0 = pc_seq;
            pc_nxt = imm;
          end
          decode_pkg::F_PUSH_CALL: begin
            push_n = 2'h2;
            pc_nxt = imm;
          end
          decode_pkg::F_TRAP: begin
            push_n = 2'h2;
            push0 = {12'h000, flags_r};
            pc_nxt = {9'h000, instr_i[14:8]} << decode_pkg::TRAP_SHIFT;
          end
          decode_pkg::F_PUSH: push_n = 2'h1;
          decode_pkg::F_POP: begin
            pop_n = 2'h1;
            wr_en = 1'b1;
            wr_val = stack_r[sp_r - SP_W'(1)];
          end
          decode_pkg::F_SWAP: begin
            push_n = 2'h1;
            wr_en = 1'b1;
            wr_val = imm;
          end
          decode_pkg::F_RET: begin
            pop_n = 2'h1;
            pc_nxt = stack_r[sp_r - SP_W'(1)];
          end
          decode_pkg::F_RET_POP: begin
            pop_n = 2'h2;
            pc_nxt = stack_r[sp_r - SP_W'(1)];
            wr_en = 1'b1;
            wr_val = stack_r[sp_r - SP_W'(2)];
          end
          default: begin
            pop_n = 2'h2;
            pc_nxt = stack_r[sp_r - SP_W'(1)];
            fl_nxt = stack_r[sp_r - SP_W'(2)][3:0];
          end
        endcase
      end
      decode_pkg::c_mac: begin
        case (lo)
          decode_pkg::C_MUL: acc_nxt = prod_s;
          decode_pkg::C_MAC: acc_nxt = acc_r + prod_s;
          decode_pkg::C_ADD: acc_nxt = acc_r + mx;
          decode_pkg::C_SUB: acc_nxt = acc_dif[31:0];
          decode_pkg::C_LOAD: acc_nxt = mx;
          decode_pkg::C_STORE: begin
            wr_en = 1'b1;
            wr_val = imm[0] ? acc_r[31:16] : acc_r[15:0];
          end
          decode_pkg::C_CMP: begin
            fl_nxt[decode_pkg::FLAG_Z] = acc_dif[31:0] == 32'h0000_0000;
            fl_nxt[decode_pkg::FLAG_N] = acc_dif[31];
            fl_nxt[decode_pkg::FLAG_C] = acc_dif[32];
          end
          decode_pkg::C_MAX: acc_nxt = ($signed(mx) > $signed(acc_r)) ? mx : acc_r;
          decode_pkg::C_MIN: acc_nxt = ($signed(mx) < $signed(acc_r)) ? mx : acc_r;
          decode_pkg::C_ABS: acc_nxt = acc_r[31] ? 32'h0000_0000 - acc_r : acc_r;
          decode_pkg::C_RND:
            acc_nxt = (acc_r + decode_pkg::ROUND_BIAS) & decode_pkg::ROUND_MASK;
          decode_pkg::C_MOV: acc_nxt = mx;
          decode_pkg::C_NEG: acc_nxt = 32'h0000_0000 - acc_r;
          default: acc_nxt = acc_r;
        endcase
      end
      default: begin
        // Page ops only load the prefix state; other system ops, the sleep opcode and illegal opcodes leave state alone.
        wr_en = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 16; i++) begin
        regs_r[i] <= 16'h0000;
      end
    end else if (instr_valid_i && wr_en) begin
      regs_r[wr_idx] <= wr_val;
    end
  end

  // Stack contents are data only; an empty pop returns stale words.
  always_ff @(posedge clock_i) begin
    if (instr_valid_i && push_n != 2'h0) begin
      stack_r[sp_r] <= push0;
      if (push_n == 2'h2) begin
        stack_r[sp_r + SP_W'(1)] <= push1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_r <= '0;
    end else if (instr_valid_i) begin
      sp_r <= sp_r + SP_W'(push_n) - SP_W'(pop_n);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_r <= decode_pkg::PC_RESET;
      flags_r <= decode_pkg::FLAGS_RESET;
      md_r <= 32'h0000_0000;
      acc_r <= 32'h0000_0000;
    end else if (instr_valid_i) begin
      pc_r <= pc_nxt;
      flags_r <= fl_nxt;
      md_r <= md_nxt;
      acc_r <= acc_nxt;
    end
  end

  // The prefix covers the next one to four instructions.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_r <= 3'h0;
      page_r <= 10'h000;
      reg_ext_r <= 1'b0;
    end else if (instr_valid_i) begin
      if (cls == decode_pkg::c_sys && lo >= decode_pkg::Y_PAGE) begin
        seq_r <= {1'b0, instr_i[13:12]} + 3'h1;
        page_r <= lo[0] ? imm[9:0] : srcv[9:0];
        reg_ext_r <= lo[2];
      end else if (seq_r != 3'h0) begin
        seq_r <= seq_r - 3'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      retire_o <= 1'b0;
      illegal_o <= 1'b0;
      dbg_data_o <= 16'h0000;
    end else begin
      retire_o <= instr_valid_i;
      illegal_o <= instr_valid_i && (cls == decode_pkg::c_bad);
      dbg_data_o <= regs_r[dbg_sel_i];
    end
  end

  assign pc_o = pc_r;
  assign flags_o = flags_r;
  assign md_o = md_r;
  assign acc_o = acc_r;
  assign page_o = page_r;

endmodule

// ===== src/length_decode.sv
// Instruction length and class from the first opcode byte.
`timescale 1ns/10ps
module length_decode (
  input wire logic [7:0] opcode_i,
  output logic [2:0] len_o,
  output decode_pkg::op_class_e cls_o
);

  logic [3:0] grp;
  logic [3:0] lo;

  assign grp = opcode_i[7:4];
  assign lo = opcode_i[3:0];

  always_comb begin
    len_o = decode_pkg::LEN_SHORT;
    cls_o = decode_pkg::c_bad;
    if (grp <= decode_pkg::GRP_MOV) begin
      if (lo[3:2] == 2'h0) begin
        cls_o = decode_pkg::c_alu;
        len_o = lo[0] ? decode_pkg::LEN_LONG : decode_pkg::LEN_SHORT;
      end
    end else if (grp == decode_pkg::GRP_MISC) begin
      cls_o = decode_pkg::c_misc;
    end else if (grp == decode_pkg::GRP_BIT) begin
      if (lo <= decode_pkg::B_SET) begin
        cls_o = decode_pkg::c_bit;
      end else if (lo <= decode_pkg::B_JLO_SET) begin
        cls_o = decode_pkg::c_bit;
        len_o = decode_pkg::LEN_LONG;
      end
    end else if (grp == decode_pkg::GRP_STEP) begin
      if (!lo[3] || !lo[1]) begin
        cls_o = decode_pkg::c_step;
        len_o = lo[2] ? decode_pkg::LEN_LONG : decode_pkg::LEN_SHORT;
      end
    end else if (grp == decode_pkg::GRP_FLOW) begin
      if (lo <= decode_pkg::F_RETI) begin
        cls_o = decode_pkg::c_flow;
        if (lo <= decode_pkg::F_PUSH_CALL || lo == decode_pkg::F_SWAP) begin
          len_o = decode_pkg::LEN_LONG;
        end
      end
    end else if (grp == decode_pkg::GRP_SYS) begin
      if (lo <= decode_pkg::Y_PAGE_RI) begin
        cls_o = decode_pkg::c_sys;
        len_o = lo[0] ? decode_pkg::LEN_LONG : decode_pkg::LEN_SHORT;
      end
    end else if (grp == decode_pkg::GRP_MAC) begin
      if (lo <= decode_pkg::C_NOP) begin
        cls_o = decode_pkg::c_mac;
        len_o = decode_pkg::LEN_LONG;
      end
    end
  end

endmodule

// ===== tb/decode_chk.sv
// Port checker for the decode core.
`timescale 1ns/10ps
module decode_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [31:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [2:0] len_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] pc_next_o,
  input wire logic retire_o,
  input wire logic illegal_o,
  input wire logic [3:0] flags_o,
  input wire logic [31:0] md_o
);
  logic sleep_w;
  logic [7:0] op_w;
  assign op_w = instr_i[7:0];
  assign sleep_w = instr_valid_i && op_w == 8'hd1;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  a_retire_each:
    assert property (instr_valid_i |=> retire_o) else $error("no retire");
  a_retire_idle:
    assert property (!instr_valid_i |=> !(retire_o || illegal_o))
    else $error("stray pulse");
  a_sleep_quiet:
    assert property (sleep_w |=> !illegal_o && $stable(md_o)
      && $stable(flags_o)) else $error("sleep changed state");
  a_sleep_skip:
    assert property (sleep_w |=> pc_o == $past(pc_o) + 16'h0004)
    else $error("sleep pc step");
  a_mac_long:
    assert property (op_w inside {[8'he0:8'hed]} |-> len_o == 3'h4)
    else $error("mac length");
  a_bitop_long:
    assert property (op_w inside {[8'ha2:8'had]} |-> len_o == 3'h4)
    else $error("bit op length");
  a_misc_short:
    assert property (op_w[7:4] == 4'h9 |-> len_o == 3'h2)
    else $error("misc length");
  a_flow_long:
    assert property (op_w inside {8'hc2, 8'hc6} |-> len_o == 3'h4)
    else $error("flow length");
  a_next_sum:
    assert property (pc_next_o == pc_o + 16'(len_o)) else $error("next pc");
  c_sleep: cover property (sleep_w);
  c_illegal: cover property (illegal_o);
  c_mac: cover property (op_w[7:4] == 4'he);
endmodule
bind insn_decode_exec decode_chk decode_chk_inst (.clock_i(clock_i),
  .nrst_i(nrst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .len_o(len_o), .pc_o(pc_o), .pc_next_o(pc_next_o), .retire_o(retire_o),
  .illegal_o(illegal_o), .flags_o(flags_o), .md_o(md_o));

// ===== tb/prog_mem.sv
// Program memory model serving instruction words to the core.
`timescale 1ns/10ps
module prog_mem (
  input wire logic [15:0] addr_i,
  output logic [31:0] data_o
);
  logic [31:0] mem [128];
  assign data_o = mem[addr_i[7:1]];
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the decode core.
`timescale 1ns/10ps
module tb_top;
  logic clock_i;
  logic nrst_i;
  logic [31:0] instr_i;
  logic instr_valid_i;
  logic [3:0] dbg_sel_i;
  logic [2:0] len_o;
  logic [15:0] pc_o;
  logic [15:0] pc_next_o;
  logic retire_o;
  logic illegal_o;
  logic [31:0] md_o;
  logic [3:0] flags_o;
  logic [31:0] acc_o;
  logic [9:0] page_o;
  logic page_active_o;
  logic reg_ext_o;
  logic instr_ready_o;
  logic [15:0] dbg_data_o;
  logic [31:0] pm_word;
  logic [15:0] rm [16];
  logic [15:0] epc;
  int n_mismatch;
  int cmp_count;
  insn_decode_exec insn_decode_exec_inst (.clock_i(clock_i), .nrst_i(nrst_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .dbg_sel_i(dbg_sel_i),
    .instr_ready_o(instr_ready_o), .len_o(len_o), .pc_o(pc_o),
    .pc_next_o(pc_next_o), .retire_o(retire_o), .illegal_o(illegal_o),
    .flags_o(flags_o), .md_o(md_o), .acc_o(acc_o), .page_o(page_o),
    .page_active_o(page_active_o), .reg_ext_o(reg_ext_o),
    .dbg_data_o(dbg_data_o));
  prog_mem prog_mem_inst (.addr_i(pc_o), .data_o(pm_word));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Expected length from the opcode byte; zero marks an opcode left open.
  function automatic int elen(input logic [7:0] op);
    case (op[7:4])
      4'h9: return 2;
      4'ha: return op[3:0] < 2 ? 2 : (op[3:0] < 14 ? 4 : 0);
      4'hb: return (op[3] && op[1]) ? 0 : (op[2] ? 4 : 2);
      4'hc: return op[3:0] inside {0, 1, 2, 6} ? 4 : (op[3:0] < 10 ? 2 : 0);
      4'hd: return op[3:0] < 6 ? (op[0] ? 4 : 2) : 0;
      4'he: return op[3:0] < 14 ? 4 : 0;
      4'hf: return 0;
      default: return op[3:0] < 4 ? (op[0] ? 4 : 2) : 0;
    endcase
  endfunction
  task automatic check(input string w, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic exec(input logic [31:0] w, input logic ill);
    prog_mem_inst.mem[epc[7:1]] = w;
    @(negedge clock_i);
    instr_i = pm_word;
    instr_valid_i = 1'b1;
    epc = epc + (elen(w[7:0]) == 0 ? 16'h0002 : 16'(elen(w[7:0])));
    @(negedge clock_i);
    instr_valid_i = 1'b0;
    check("pc", 32'(epc), 32'(pc_o));
    check("retire", 32'h1, 32'(retire_o));
    check("ready", 32'h1, 32'(instr_ready_o));
    check("illegal", 32'(ill), 32'(illegal_o));
  endtask
  task automatic peek(input logic [3:0] r);
    dbg_sel_i = r;
    @(negedge clock_i);
    check("reg", 32'(rm[r]), 32'(dbg_data_o));
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock_i);
    n_mismatch++;
    complete_run();
  end
  initial begin
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0] k;
    int p;
    int q;
    int d;
    void'($urandom(32'hd1a49b40));
    nrst_i = 1'b0;
    instr_i = 32'h0;
    instr_valid_i = 1'b0;
    dbg_sel_i = 4'h0;
    epc = 16'h0;
    repeat (4) @(negedge clock_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(negedge clock_i);
      instr_i = {24'($urandom()), 8'(i)};
      #1;
      if (elen(8'(i)) != 0) begin
        check("len", 32'(elen(8'(i))), 32'(len_o));
        check("next", 32'(epc) + elen(8'(i)), 32'(pc_next_o));
      end
    end
    $display("length sweep done");
    for (int t = 0; t < 6; t++) begin
      a = 16'($urandom());
      b = 16'($urandom());
      k = 4'($urandom());
      exec({a, 8'h10, 8'h81}, 1'b0);
      exec({b, 8'h20, 8'h81}, 1'b0);
      rm[1] = a;
      rm[2] = b;
      exec(32'h0000_1290, 1'b0);
      check("md", 32'($signed(a)) * 32'($signed(b)), md_o);
      p = $signed(a) * $signed(b);
      d = $signed(b);
      q = 32'($signed(p[15:0]));
      if (d != 0) begin
        p = {16'(q % d), 16'(q / d)};
      end
      exec(32'h0000_1292, 1'b0);
      check("div", 32'(p), md_o);
      check("div_v", 32'(d == 0), 32'(flags_o[2]));
      exec({16'h0, 4'h1, k, 8'h9e}, 1'b0);
      rm[1] = 16'($signed(a) >>> k);
      exec(32'h0000_2098, 1'b0);
      rm[2] = -b;
      exec(32'h0000_2097, 1'b0);
      rm[2][7:0] = ~rm[2][7:0];
      exec({6'h00, a[9:0], 8'h00, 8'hd5}, 1'b0);
      check("page", 32'(a[9:0]), 32'(page_o));
      check("seq", 32'h3, 32'({page_active_o, reg_ext_o}));
      exec(32'h0000_12e4, 1'b0);
      check("acc", {rm[1], rm[2]}, acc_o);
      check("seq", 32'h0, 32'({page_active_o, reg_ext_o}));
      exec({8'h00, b[7:0], 8'h30, 8'hbc}, 1'b0);
      rm[3] = 16'($signed(b[7:0]));
      exec(32'h0000_1202, 1'b0);
      p = rm[1][7:0] + rm[2][7:0];
      rm[1][7:0] = p[7:0];
      check("carry", 32'(p[8]), 32'(flags_o[0]));
      exec(32'h0000_00d1, 1'b0);
      exec(32'h0000_00f0, 1'b1);
      peek(4'h1);
      peek(4'h2);
      peek(4'h3);
    end
    $display("execute walk done");
    complete_run();
  end
endmodule
